// *** i2camr_peer.sv ***
// Purpose: bus-side peer giving one-cycle event pulses
// Assumes: bit 0 address, 1 rx, 2 tx empty, 3..9 start to ninth bit
// Notes: address lines toggle when not valid
`timescale 1ns/10ps
module i2camr_peer (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [9:0] req_in,
    input wire logic [9:0] addr_in,
    output logic [9:0] ev_out,
    output logic [9:0] bus_addr_out
);
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ev_out <= 10'h000;
            bus_addr_out <= 10'h000;
        end else begin
            ev_out <= req_in;
            bus_addr_out <= req_in[0] ? addr_in : ~bus_addr_out;
        end
    end
endmodule

// *** i2camr_pkg.sv ***
// Purpose: constants and state type of the i2c address, mask and irq-enable bank
// Assumes: 16-bit register port, word index addressing
// Notes: one packed struct carries all state of the bank
package i2camr_pkg;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned SADDR_W = 10;
    localparam int unsigned NUM_OWN = 4;
    // register indices
    localparam logic [3:0] REG_CONTROL = 4'h0;
    localparam logic [3:0] REG_OWN_ADDR0 = 4'h1;
    localparam logic [3:0] REG_RX_ADDR = 4'h5;
    localparam logic [3:0] REG_ADDR_MASK = 4'h6;
    localparam logic [3:0] REG_TARGET = 4'h7;
    localparam logic [3:0] REG_IRQ_EN = 4'h8;
    localparam logic [3:0] REG_IRQ_FLAG = 4'h9;
    // control fields and own-address enable bit
    localparam int unsigned CTL_SOFT_RST_BIT = 0;
    localparam int unsigned CTL_MASTER_BIT = 1;
    localparam int unsigned CTL_TEN_BIT = 2;
    localparam int unsigned OWN_EN_BIT = 10;
    // interrupt bit positions, shared by enable and flag registers
    localparam int unsigned IRQ_RX0 = 0;
    localparam int unsigned IRQ_TX0 = 1;
    localparam int unsigned IRQ_START = 2;
    localparam int unsigned IRQ_STOP = 3;
    localparam int unsigned IRQ_ARB = 4;
    localparam int unsigned IRQ_NACK = 5;
    localparam int unsigned IRQ_BCNT = 6;
    localparam int unsigned IRQ_CLTO = 7;
    localparam int unsigned IRQ_RX1 = 8;
    localparam int unsigned IRQ_BIT9 = 14;
    // reset values and field masks
    localparam logic [2:0] CONTROL_RST = 3'h1;
    localparam logic [9:0] MASK_RST = 10'h3ff;
    localparam logic [9:0] SEVEN_BIT_FIELD = 10'h07f;
    localparam logic [15:0] IRQ_EN_RST = 16'h0000;
    localparam logic [15:0] IRQ_FLAG_RST = 16'h0002;
    localparam logic [15:0] IRQ_VALID = 16'h7fff;

    typedef struct packed {
        logic [2:0] control;
        logic [3:0][10:0] own_addr;
        logic [9:0] last_rx_address;
        logic [9:0] address_compare_mask;
        logic [9:0] target_address;
        logic [15:0] irq_en;
        logic [15:0] irq_flag;
        logic [3:0] frame_match;
        logic [3:0] addr_match;
        logic [9:0] target_out;
        logic [15:0] rd_data;
        logic irq;
    } i2camr_state_type;
endpackage

// *** i2camr_regs.sv ***
// Purpose: address capture, address mask, target address and interrupt enables
// Assumes: protocol engine delivers one-cycle event pulses on ref_clk_in
// Notes: all outputs come from the state register
`timescale 1ns/10ps
module i2camr_regs (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    input wire logic addr_seen_in,
    input wire logic [9:0] bus_addr_in,
    input wire logic rx_byte_in,
    input wire logic tx_empty_in,
    input wire logic start_seen_in,
    input wire logic stop_seen_in,
    input wire logic arb_lost_in,
    input wire logic no_ack_in,
    input wire logic byte_count_in,
    input wire logic clock_low_timeout_in,
    input wire logic ninth_bit_in,
    output logic [3:0] addr_match_out,
    output logic [9:0] target_address_out,
    output logic master_mode_out,
    output logic ten_bit_mode_out,
    output logic module_soft_reset_out,
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // state
    i2camr_pkg::i2camr_state_type s_q;
    i2camr_pkg::i2camr_state_type s_d;

    logic [9:0] cmp_mask;
    logic [3:0] hit;
    logic [15:0] set_ev;
    logic [15:0] clr_ev;
    logic [15:0] rd_word;
    logic soft_rst;
    logic master;
    logic ten_bit;

    assign soft_rst = s_q.control[i2camr_pkg::CTL_SOFT_RST_BIT];
    assign master = s_q.control[i2camr_pkg::CTL_MASTER_BIT];
    assign ten_bit = s_q.control[i2camr_pkg::CTL_TEN_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // address compare
    always_comb begin
        // seven-bit mode drops bits 9..7 from the compare
        if (ten_bit) begin
            cmp_mask = s_q.address_compare_mask;
        end else begin
            cmp_mask = s_q.address_compare_mask & i2camr_pkg::SEVEN_BIT_FIELD;
        end
        for (int i = 0; i < 4; i++) begin
            hit[i] = s_q.own_addr[i][i2camr_pkg::OWN_EN_BIT]
                && !soft_rst && !master && addr_seen_in
                && (((bus_addr_in ^ s_q.own_addr[i][9:0]) & cmp_mask) == 10'h000);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // event set terms
    always_comb begin
        set_ev = 16'h0000;
        set_ev[i2camr_pkg::IRQ_RX0] = rx_byte_in && !master && s_q.frame_match[0];
        set_ev[i2camr_pkg::IRQ_TX0] = tx_empty_in && (master || s_q.frame_match[0]);
        for (int i = 1; i < 4; i++) begin
            set_ev[i2camr_pkg::IRQ_RX1 + 2 * (i - 1)] =
                rx_byte_in && !master && s_q.frame_match[i];
            set_ev[i2camr_pkg::IRQ_RX1 + 2 * (i - 1) + 1] =
                tx_empty_in && !master && s_q.frame_match[i];
        end
        set_ev[i2camr_pkg::IRQ_START] = start_seen_in;
        set_ev[i2camr_pkg::IRQ_STOP] = stop_seen_in;
        set_ev[i2camr_pkg::IRQ_ARB] = arb_lost_in;
        set_ev[i2camr_pkg::IRQ_NACK] = no_ack_in && master;
        set_ev[i2camr_pkg::IRQ_BCNT] = byte_count_in;
        set_ev[i2camr_pkg::IRQ_CLTO] = clock_low_timeout_in;
        set_ev[i2camr_pkg::IRQ_BIT9] = ninth_bit_in;
        if (soft_rst) begin
            set_ev = 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read mux
    always_comb begin
        rd_word = 16'h0000;
        unique case (reg_addr_in)
            i2camr_pkg::REG_CONTROL: begin
                rd_word = {13'h0000, s_q.control};
            end
            4'h1, 4'h2, 4'h3, 4'h4: begin
                rd_word = {5'h00, s_q.own_addr[2'(reg_addr_in - i2camr_pkg::REG_OWN_ADDR0)]};
            end
            i2camr_pkg::REG_RX_ADDR: begin
                rd_word = {6'h00, s_q.last_rx_address};
            end
            i2camr_pkg::REG_ADDR_MASK: begin
                rd_word = {6'h00, s_q.address_compare_mask};
            end
            i2camr_pkg::REG_TARGET: begin
                rd_word = {6'h00, s_q.target_address};
            end
            i2camr_pkg::REG_IRQ_EN: begin
                rd_word = s_q.irq_en & i2camr_pkg::IRQ_VALID;
            end
            i2camr_pkg::REG_IRQ_FLAG: begin
                rd_word = s_q.irq_flag & i2camr_pkg::IRQ_VALID;
            end
            default: begin
                rd_word = 16'h0000;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_d = s_q;
        clr_ev = 16'h0000;
        // register writes
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                i2camr_pkg::REG_CONTROL: begin
                    s_d.control = reg_wdata_in[2:0];
                end
                4'h1, 4'h2, 4'h3, 4'h4: begin
                    s_d.own_addr[2'(reg_addr_in - i2camr_pkg::REG_OWN_ADDR0)] =
                        reg_wdata_in[10:0];
                end
                i2camr_pkg::REG_ADDR_MASK: begin
                    if (soft_rst) begin
                        s_d.address_compare_mask = reg_wdata_in[9:0];
                    end
                end
                i2camr_pkg::REG_TARGET: begin
                    s_d.target_address = reg_wdata_in[9:0];
                end
                i2camr_pkg::REG_IRQ_EN: begin
                    s_d.irq_en = reg_wdata_in & i2camr_pkg::IRQ_VALID;
                end
                i2camr_pkg::REG_IRQ_FLAG: begin
                    clr_ev = reg_wdata_in;
                end
                default: begin
                    s_d.control = s_q.control;
                end
            endcase
        end
        // address capture and frame tracking
        if (addr_seen_in && !soft_rst) begin
            s_d.last_rx_address = bus_addr_in;
            s_d.frame_match = hit;
        end
        if (stop_seen_in || soft_rst) begin
            s_d.frame_match = 4'h0;
        end
        s_d.addr_match = hit;
        // sticky flags, set wins over write-one-clear
        s_d.irq_flag = ((s_q.irq_flag & ~clr_ev) | set_ev) & i2camr_pkg::IRQ_VALID;
        // target address presented to the master engine
        if (s_d.control[i2camr_pkg::CTL_MASTER_BIT]) begin
            if (s_d.control[i2camr_pkg::CTL_TEN_BIT]) begin
                s_d.target_out = s_d.target_address;
            end else begin
                s_d.target_out = s_d.target_address & i2camr_pkg::SEVEN_BIT_FIELD;
            end
        end else begin
            s_d.target_out = 10'h000;
        end
        // gated interrupt request
        s_d.irq = |(s_d.irq_flag & s_d.irq_en);
        s_d.rd_data = reg_rd_in ? rd_word : 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_q.control <= i2camr_pkg::CONTROL_RST;
            s_q.own_addr <= '0;
            s_q.last_rx_address <= 10'h000;
            s_q.address_compare_mask <= i2camr_pkg::MASK_RST;
            s_q.target_address <= 10'h000;
            s_q.irq_en <= i2camr_pkg::IRQ_EN_RST;
            s_q.irq_flag <= i2camr_pkg::IRQ_FLAG_RST;
            s_q.frame_match <= 4'h0;
            s_q.addr_match <= 4'h0;
            s_q.target_out <= 10'h000;
            s_q.rd_data <= 16'h0000;
            s_q.irq <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign reg_rdata_out = s_q.rd_data;
    assign addr_match_out = s_q.addr_match;
    assign target_address_out = s_q.target_out;
    assign master_mode_out = master;
    assign ten_bit_mode_out = ten_bit;
    assign module_soft_reset_out = soft_rst;
    assign irq_out = s_q.irq;
endmodule

// *** i2camr_sva.sv ***
// Purpose: port checker of the address, mask and irq-enable bank
// Assumes: one clock, reset active high
// Notes: bound to every bank instance
`timescale 1ns/10ps
module i2camr_sva (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic addr_seen_in,
    input wire logic [3:0] addr_match_out,
    input wire logic [9:0] target_address_out,
    input wire logic master_mode_out,
    input wire logic ten_bit_mode_out,
    input wire logic module_soft_reset_out,
    input wire logic irq_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////////////////////
    rx_high_a: assert property (reg_rd_in && reg_addr_in == 4'h5 |=> !reg_rdata_out[15:10])
        else $error("received address high bits set");
    mask_high_a: assert property (reg_rd_in && reg_addr_in == 4'h6 |=> !reg_rdata_out[15:10])
        else $error("mask high bits set");
    en_top_a: assert property (reg_rd_in && reg_addr_in == 4'h8 |=> !reg_rdata_out[15])
        else $error("enable bit 15 set");
    target_idle_a: assert property (!master_mode_out && !$past(master_mode_out)
        |-> target_address_out == 10'h000) else $error("target driven outside master");
    seven_bit_a: assert property (master_mode_out && !ten_bit_mode_out &&
        $past(master_mode_out) && !$past(ten_bit_mode_out) |-> !target_address_out[9:7])
        else $error("target bits 9..7 in seven-bit mode");
    match_cause_a: assert property (addr_match_out != 4'h0 |-> $past(addr_seen_in))
        else $error("match without address");
    match_soft_a: assert property (addr_seen_in && module_soft_reset_out
        |=> !addr_match_out) else $error("match during soft reset");
    irq_off_a: assert property (reg_wr_in && reg_addr_in == 4'h8 && !reg_wdata_in
        |=> !irq_out) else $error("irq with all enables off");
    match_c: cover property (addr_match_out[0]);
    irq_c: cover property ($rose(irq_out));
    ten_c: cover property (master_mode_out && ten_bit_mode_out);
    multi_c: cover property (addr_match_out == 4'h3);
endmodule
bind i2camr_regs i2camr_sva u_sva (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .addr_seen_in(addr_seen_in),
    .addr_match_out(addr_match_out), .target_address_out(target_address_out),
    .master_mode_out(master_mode_out), .ten_bit_mode_out(ten_bit_mode_out),
    .module_soft_reset_out(module_soft_reset_out), .irq_out(irq_out));

// *** tb_top.sv ***
// Purpose: self-checking bench of the address, mask and irq-enable bank
// Assumes: 25 MHz clock, peer model supplies bus events
// Notes: expectations worked out from own-address and mask values
`timescale 1ns/10ps
module tb_top;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic [9:0] req = 10'h000;
    logic [9:0] req_addr = 10'h000;
    logic [9:0] ev, bus_addr, target_address_out;
    logic [15:0] reg_rdata_out;
    logic [3:0] addr_match_out;
    logic master_mode_out, ten_bit_mode_out, module_soft_reset_out, irq_out;
    int n_errors = 0;
    int check_count = 0;
    integer seed = 81430;
    logic [15:0] a, hit;
    logic [15:0] m_en = 16'h0000;
    logic [15:0] m_flag = 16'h0002;
    logic [15:0] addr_q[$];
    logic [15:0] irq_w, modes;
    int fbit [6] = '{2, 3, 4, 6, 7, 14};
    int pidx [6] = '{3, 4, 5, 7, 8, 9};
    initial begin
        forever #20 ref_clk_in = ~ref_clk_in;
    end
    i2camr_peer u_peer (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .req_in(req),
        .addr_in(req_addr), .ev_out(ev), .bus_addr_out(bus_addr));
    i2camr_regs DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .addr_seen_in(ev[0]), .bus_addr_in(bus_addr),
        .rx_byte_in(ev[1]), .tx_empty_in(ev[2]), .start_seen_in(ev[3]), .stop_seen_in(ev[4]),
        .arb_lost_in(ev[5]), .no_ack_in(ev[6]), .byte_count_in(ev[7]),
        .clock_low_timeout_in(ev[8]), .ninth_bit_in(ev[9]), .addr_match_out(addr_match_out),
        .target_address_out(target_address_out), .master_mode_out(master_mode_out),
        .ten_bit_mode_out(ten_bit_mode_out), .module_soft_reset_out(module_soft_reset_out),
        .irq_out(irq_out));
    assign irq_w = {15'h0000, irq_out};
    assign modes = {13'h0000, ten_bit_mode_out, master_mode_out, module_soft_reset_out};
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] m_irq();
        return {15'h0000, |(m_flag & m_en)};
    endfunction
    task automatic wr(input logic [3:0] ad, input logic [15:0] d);
        if (ad == 4'h8) begin
            m_en = d & 16'h7fff;
        end
        if (ad == 4'h9) begin
            m_flag = m_flag & ~d;
        end
        @(posedge ref_clk_in);
        reg_addr_in <= ad;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] ad, input logic [15:0] exp);
        @(posedge ref_clk_in);
        reg_addr_in <= ad;
        reg_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        #1 chk(reg_rdata_out, exp);
    endtask
    task automatic pulse(input int i, input logic [9:0] ad);
        @(posedge ref_clk_in);
        req <= 10'h001 << i;
        req_addr <= ad;
        @(posedge ref_clk_in);
        req <= 10'h000;
        @(posedge ref_clk_in);
        #1;
    endtask
    task automatic settle(input logic [15:0] exp);
        repeat (2) @(posedge ref_clk_in);
        #1 chk({6'h00, target_address_out}, exp);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        rd(4'h6, 16'h03ff);
        rd(4'h5, 16'h0000);
        rd(4'h9, m_flag);
        rd(4'hf, 16'h0000);
        rd(4'h0, 16'h0001);
        chk(modes, 16'h0001);
        wr(4'h8, 16'hffff);
        rd(4'h8, 16'h7fff);
        wr(4'h8, 16'h0000);
        wr(4'h9, 16'h0002);
        wr(4'h6, 16'h03fc);
        wr(4'h1, 16'h0455);
        pulse(0, 10'h055);
        chk({12'h000, addr_match_out}, 16'h0000);
        wr(4'h0, 16'h0000);
        wr(4'h6, 16'h0000);
        rd(4'h6, 16'h03fc);
        for (int k = 0; k < 10; k++) begin
            a = (k == 0) ? 16'h0056 : 16'h007f & 16'($random(seed));
            hit = {15'h0000, ((a ^ 16'h0055) & 16'h007c) == 16'h0000};
            addr_q.push_back(a);
            pulse(0, a[9:0]);
            chk({12'h000, addr_match_out}, hit);
            rd(4'h5, addr_q[$]);
        end
        wr(4'h2, 16'h0455);
        pulse(0, 10'h055);
        chk({12'h000, addr_match_out}, 16'h0003);
        pulse(1, 10'h000);
        pulse(2, 10'h000);
        m_flag = m_flag | 16'h0303;
        rd(4'h9, m_flag);
        wr(4'h9, 16'h0303);
        for (int k = 0; k < 6; k++) begin
            wr(4'h8, 16'h7fff ^ (16'h0001 << fbit[k]));
            pulse(pidx[k], 10'h000);
            m_flag = m_flag | (16'h0001 << fbit[k]);
            chk(irq_w, m_irq());
            rd(4'h9, m_flag);
            wr(4'h8, 16'h0001 << fbit[k]);
            repeat (2) @(posedge ref_clk_in);
            #1 chk(irq_w, m_irq());
            wr(4'h9, 16'h0001 << fbit[k]);
            repeat (2) @(posedge ref_clk_in);
            #1 chk(irq_w, m_irq());
        end
        wr(4'h7, 16'h03a5);
        wr(4'h0, 16'h0002);
        settle(16'h0025);
        wr(4'h0, 16'h0006);
        settle(16'h03a5);
        chk(modes, 16'h0006);
        wr(4'h8, 16'h0020);
        pulse(6, 10'h000);
        m_flag = m_flag | 16'h0020;
        chk(irq_w, m_irq());
        wr(4'h0, 16'h0000);
        settle(16'h0000);
        chk(modes, 16'h0000);
        final_report();
    end
endmodule
